// ### rtl/dee_cfg.svh
// Device addresses, control codes, host register map and timing counts of the data EEPROM host.
`ifndef DEE_CFG_SVH
`define DEE_CFG_SVH
// Registers of the nonvolatile controller inside the device.
`define DEE_DEV_CTRL_ADDR 16'h0760
`define DEE_DEV_ADRL_ADDR 16'h0762
`define DEE_DEV_ADRU_ADDR 16'h0764
`define DEE_DEV_KEY_ADDR 16'h0766
`define DEE_DEV_FLAG_ADDR 16'h0084
`define DEE_FLAG_MASK 16'h1000
// Control register fields and the three launch codes.
`define DEE_GO_BIT 15
`define DEE_EN_BIT 14
`define DEE_ERR_BIT 13
`define DEE_GO_MASK 16'h8000
`define DEE_EN_MASK 16'h4000
`define DEE_CODE_BLK_ERASE 16'h4045
`define DEE_CODE_WORD_ERASE 16'h4044
`define DEE_CODE_PROGRAM 16'h4004
`define DEE_KEY_FIRST 16'h0055
`define DEE_KEY_SECOND 16'h00aa
// Host register byte offsets on APB.
`define DEE_CMD_OFS 12'h000
`define DEE_ADR_OFS 12'h004
`define DEE_WDAT_OFS 12'h008
`define DEE_STAT_OFS 12'h00c
`define DEE_RDAT_OFS 12'h010
`define DEE_CMD_START_BIT 8
`define DEE_ST_BUSY 0
`define DEE_ST_DONE 1
`define DEE_ST_ERR 2
`define DEE_ST_LATE 3
// Erase or program cycle time and the clock period.
`define DEE_CYCLE_TIME_NS 2000000
`define DEE_CLK_PERIOD_NS 10
`define DEE_CYCLE_CYC (`DEE_CYCLE_TIME_NS / `DEE_CLK_PERIOD_NS)
`define DEE_POLL_WAIT_MAX 40
`endif

// ### rtl/dee_dev_port.sv
// Request port that holds one device access until the device acknowledges it.
`timescale 1ns/1ps
module dee_dev_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  input wire dee_pkg::dee_dreq_t req,
  output logic done,
  output logic [15:0] rdata,
  output logic dev_valid,
  output dee_pkg::dee_dreq_t dev_req,
  input wire logic dev_ack,
  input wire logic [15:0] dev_rdata
);
  logic dev_valid_ff;
  logic done_ff;
  logic [15:0] rdata_ff;
  dee_pkg::dee_dreq_t dev_req_ff;

  // The request stands unchanged until the device takes it with dev_ack.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_valid_ff <= 1'b0;
      dev_req_ff <= '0;
    end else if (ce) begin
      if (dev_valid_ff && dev_ack) begin
        dev_valid_ff <= 1'b0;
      end else if (start && !dev_valid_ff) begin
        dev_valid_ff <= 1'b1;
        dev_req_ff <= req;
      end
    end
  end

  // Completion pulse with the read word captured on the accepting edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else if (ce) begin
      done_ff <= dev_valid_ff && dev_ack;
      if (dev_valid_ff && dev_ack) begin
        rdata_ff <= dev_rdata;
      end
    end
  end

  assign done = done_ff;
  assign rdata = rdata_ff;
  assign dev_valid = dev_valid_ff;
  assign dev_req = dev_req_ff;

  a_req_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ce && dev_valid_ff && !dev_ack |=> dev_valid_ff && $stable(dev_req_ff)
  ) else $error("Device request changed before it was acknowledged.");
endmodule : dee_dev_port

// ### rtl/dee_host.sv
// Host controller that sequences data EEPROM reads, erases and word programming.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "dee_cfg.svh"
module dee_host #(
  parameter int unsigned CYCLE_CYC = `DEE_CYCLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic dev_valid,
  output dee_pkg::dee_dreq_t dev_req,
  input wire logic dev_ack,
  input wire logic [15:0] dev_rdata
);
  dee_pkg::dee_st_t st_ff;
  dee_pkg::dee_st_t nxt_st;
  dee_pkg::dee_cmd_t cmd_ff;
  dee_pkg::dee_dreq_t req;
  dee_pkg::dee_dreq_t prev_req_ff;
  logic [22:0] addr_ff;
  logic [15:0] wdat_ff, rdat_ff, flag_ff, last_ctrl_ff, code, prd;
  logic [31:0] rd_val, prdata_ff;
  logic pready_ff, pslverr_ff, done_ff, err_ff, late_ff, issued_ff, phase_ff, live_ff;
  logic setup, wr_acc, stat_wr, hit, launch, busy, start, pdone, tmr_exp, fin, poll_end;

  // APB phases; a write takes effect only at the edge that samples pready high.
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_ff;
  assign stat_wr = wr_acc && (paddr == `DEE_STAT_OFS);
  assign busy = (st_ff != dee_pkg::ST_IDLE);
  assign launch = wr_acc && (paddr == `DEE_CMD_OFS) && pwdata[`DEE_CMD_START_BIT] && !busy;
  assign start = busy && !issued_ff;
  assign poll_end = (st_ff == dee_pkg::ST_POLL) && pdone && !prd[`DEE_GO_BIT];
  assign fin = pdone && (st_ff == dee_pkg::ST_DISEN || st_ff == dee_pkg::ST_TREAD);

  // Read decode; an unmapped offset reads zero and answers with pslverr.
  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    if (paddr == `DEE_CMD_OFS) begin
      rd_val[1:0] = cmd_ff;
    end else if (paddr == `DEE_ADR_OFS) begin
      rd_val[22:0] = addr_ff;
    end else if (paddr == `DEE_WDAT_OFS) begin
      rd_val[15:0] = wdat_ff;
    end else if (paddr == `DEE_STAT_OFS) begin
      rd_val[`DEE_ST_BUSY] = busy;
      rd_val[`DEE_ST_DONE] = done_ff;
      rd_val[`DEE_ST_ERR] = err_ff;
      rd_val[`DEE_ST_LATE] = late_ff;
    end else if (paddr == `DEE_RDAT_OFS) begin
      rd_val[15:0] = rdat_ff;
    end else begin
      hit = 1'b0;
    end
  end

  // The answer is prepared at the setup edge, so every access has no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      pready_ff <= setup;
      pslverr_ff <= setup && !hit;
      if (setup) begin
        prdata_ff <= rd_val;
      end
    end
  end

  // Order registers; they are frozen while busy so a running sequence stays coherent.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_ff <= dee_pkg::CMD_READ;
      addr_ff <= 23'h000000;
      wdat_ff <= 16'h0000;
    end else if (ce && wr_acc && !busy) begin
      if (paddr == `DEE_CMD_OFS) begin
        cmd_ff <= dee_pkg::dee_cmd_t'(pwdata[1:0]);
      end else if (paddr == `DEE_ADR_OFS) begin
        addr_ff <= pwdata[22:0];
      end else if (paddr == `DEE_WDAT_OFS) begin
        wdat_ff <= pwdata[15:0];
      end
    end
  end

  // Sticky status bits; a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      late_ff <= 1'b0;
      rdat_ff <= 16'h0000;
    end else if (ce) begin
      done_ff <= fin || (done_ff && !(stat_wr && pwdata[`DEE_ST_DONE]));
      err_ff <= (poll_end && prd[`DEE_ERR_BIT]) || (err_ff && !(stat_wr && pwdata[`DEE_ST_ERR]));
      late_ff <= tmr_exp || (late_ff && !(stat_wr && pwdata[`DEE_ST_LATE]));
      if (st_ff == dee_pkg::ST_TREAD && pdone) begin
        rdat_ff <= prd;
      end
    end
  end

  // Launch code: erase word first, program in the second phase of a word write.
  always_comb begin
    if (cmd_ff == dee_pkg::CMD_ERASE_BLOCK) begin
      code = `DEE_CODE_BLK_ERASE;
    end else if (cmd_ff == dee_pkg::CMD_WRITE_WORD && phase_ff) begin
      code = `DEE_CODE_PROGRAM;
    end else begin
      code = `DEE_CODE_WORD_ERASE;
    end
  end

  // Next state; each step waits for the device to take its access.
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      dee_pkg::ST_IDLE: begin
        if (launch && dee_pkg::dee_cmd_t'(pwdata[1:0]) == dee_pkg::CMD_READ) begin
          nxt_st = dee_pkg::ST_TREAD;
        end else if (launch) begin
          nxt_st = dee_pkg::ST_ADRL;
        end
      end
      dee_pkg::ST_ADRL: if (pdone) nxt_st = dee_pkg::ST_ADRU;
      dee_pkg::ST_ADRU: if (pdone) nxt_st = dee_pkg::ST_CTRL;
      dee_pkg::ST_CTRL: if (pdone) nxt_st = dee_pkg::ST_KEY1;
      dee_pkg::ST_KEY1: if (pdone) nxt_st = dee_pkg::ST_KEY2;
      dee_pkg::ST_KEY2: if (pdone) nxt_st = dee_pkg::ST_GO;
      dee_pkg::ST_GO: if (pdone) nxt_st = dee_pkg::ST_POLL;
      dee_pkg::ST_POLL: if (poll_end) nxt_st = dee_pkg::ST_FLRD;
      dee_pkg::ST_FLRD: if (pdone) nxt_st = dee_pkg::ST_FLWR;
      dee_pkg::ST_FLWR: begin
        if (pdone && cmd_ff == dee_pkg::CMD_WRITE_WORD && !phase_ff) begin
          nxt_st = dee_pkg::ST_TSTORE;
        end else if (pdone) begin
          nxt_st = dee_pkg::ST_DISEN;
        end
      end
      dee_pkg::ST_TSTORE: if (pdone) nxt_st = dee_pkg::ST_CTRL;
      dee_pkg::ST_TREAD: if (pdone) nxt_st = dee_pkg::ST_IDLE;
      dee_pkg::ST_DISEN: if (pdone) nxt_st = dee_pkg::ST_IDLE;
      default: nxt_st = dee_pkg::ST_IDLE;
    endcase
  end

  // Device access that belongs to each step.
  always_comb begin
    req = '0;
    req.op = dee_pkg::DOP_REG_WR;
    req.addr = `DEE_DEV_CTRL_ADDR;
    case (st_ff)
      dee_pkg::ST_ADRL: begin
        req.addr = `DEE_DEV_ADRL_ADDR;
        req.data = addr_ff[15:0];
      end
      dee_pkg::ST_ADRU: begin
        req.addr = `DEE_DEV_ADRU_ADDR;
        req.data = {9'h000, addr_ff[22:16]};
      end
      dee_pkg::ST_CTRL: req.data = code;
      dee_pkg::ST_KEY1: begin
        req.addr = `DEE_DEV_KEY_ADDR;
        req.data = `DEE_KEY_FIRST;
      end
      dee_pkg::ST_KEY2: begin
        req.addr = `DEE_DEV_KEY_ADDR;
        req.data = `DEE_KEY_SECOND;
      end
      dee_pkg::ST_GO: req.data = code | `DEE_GO_MASK;
      dee_pkg::ST_POLL: req.op = dee_pkg::DOP_REG_RD;
      dee_pkg::ST_FLRD: begin
        req.op = dee_pkg::DOP_REG_RD;
        req.addr = `DEE_DEV_FLAG_ADDR;
      end
      dee_pkg::ST_FLWR: begin
        req.addr = `DEE_DEV_FLAG_ADDR;
        req.data = flag_ff & ~`DEE_FLAG_MASK;
      end
      dee_pkg::ST_TSTORE: begin
        req.op = dee_pkg::DOP_TBL_ST;
        req.page = addr_ff[22:16];
        req.addr = addr_ff[15:0];
        req.data = wdat_ff;
      end
      dee_pkg::ST_TREAD: begin
        req.op = dee_pkg::DOP_TBL_RD;
        req.page = addr_ff[22:16];
        req.addr = addr_ff[15:0];
      end
      dee_pkg::ST_DISEN: req.data = code & ~`DEE_EN_MASK;
      default: req.data = 16'h0000;
    endcase
  end

  // State register; enable is dropped only after the cycle has ended, never midway.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= dee_pkg::ST_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // One access in flight at a time; the flag drops with its completion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      issued_ff <= 1'b0;
    end else if (ce) begin
      issued_ff <= !pdone && (issued_ff || start);
    end
  end

  // Phase, saved flag word and bookkeeping of issued accesses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
      flag_ff <= 16'h0000;
      last_ctrl_ff <= 16'h0000;
      prev_req_ff <= '0;
      live_ff <= 1'b0;
    end else if (ce) begin
      if (launch) begin
        phase_ff <= 1'b0;
      end else if (st_ff == dee_pkg::ST_FLWR && pdone) begin
        phase_ff <= 1'b1;
      end
      if (st_ff == dee_pkg::ST_FLRD && pdone) begin
        flag_ff <= prd;
      end
      if (start && req.op == dee_pkg::DOP_REG_WR && req.addr == `DEE_DEV_CTRL_ADDR) begin
        last_ctrl_ff <= req.data;
      end
      if (start) begin
        prev_req_ff <= req;
      end
      if (start && st_ff == dee_pkg::ST_GO) begin
        live_ff <= 1'b1;
      end else if (poll_end) begin
        live_ff <= 1'b0;
      end
    end
  end

  dee_dev_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(start),
    .req(req),
    .done(pdone),
    .rdata(prd),
    .dev_valid(dev_valid),
    .dev_req(dev_req),
    .dev_ack(dev_ack),
    .dev_rdata(dev_rdata)
  );

  dee_tmr #(.CYC(CYCLE_CYC)) u_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(st_ff == dee_pkg::ST_POLL),
    .expired(tmr_exp)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

  // Checks on the sequence that the device sees.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_aa_after_55: assert property (
    start && req.addr == `DEE_DEV_KEY_ADDR && req.data == `DEE_KEY_SECOND
    |-> prev_req_ff.addr == `DEE_DEV_KEY_ADDR && prev_req_ff.data == `DEE_KEY_FIRST
  ) else $error("Second key not preceded by the first key.");
  a_go_after_keys: assert property (
    start && st_ff == dee_pkg::ST_GO
    |-> prev_req_ff.addr == `DEE_DEV_KEY_ADDR && prev_req_ff.data == `DEE_KEY_SECOND && req.data[`DEE_GO_BIT]
  ) else $error("Go issued without the key pair just before it.");
  a_go_needs_en: assert property (
    start && req.op == dee_pkg::DOP_REG_WR && req.addr == `DEE_DEV_CTRL_ADDR && req.data[`DEE_GO_BIT]
    |-> last_ctrl_ff[`DEE_EN_BIT] && !last_ctrl_ff[`DEE_GO_BIT]
  ) else $error("Go written without enable set by an earlier write.");
  a_blk_code: assert property (
    start && st_ff == dee_pkg::ST_CTRL && cmd_ff == dee_pkg::CMD_ERASE_BLOCK |-> req.data == `DEE_CODE_BLK_ERASE
  ) else $error("Block erase launched with the wrong control code.");
  a_word_code: assert property (
    start && st_ff == dee_pkg::ST_CTRL && cmd_ff == dee_pkg::CMD_ERASE_WORD |-> req.data == `DEE_CODE_WORD_ERASE
  ) else $error("Word erase launched with the wrong control code.");
  a_prog_order: assert property (
    start && st_ff == dee_pkg::ST_CTRL && req.data == `DEE_CODE_PROGRAM
    |-> phase_ff && prev_req_ff.op == dee_pkg::DOP_TBL_ST && $past(st_ff, 2) == dee_pkg::ST_TSTORE
  ) else $error("Program launched without erase and latch load first.");
  a_flag_cleared: assert property (
    poll_end |-> ##[1:40] (start && req.addr == `DEE_DEV_FLAG_ADDR && req.op == dee_pkg::DOP_REG_WR
      && (req.data & `DEE_FLAG_MASK) == 16'h0000)
  ) else $error("Done flag not cleared after the cycle ended.");
  a_enable_off: assert property (
    st_ff == dee_pkg::ST_DISEN && pdone |=> !busy && !last_ctrl_ff[`DEE_EN_BIT] && done_ff
  ) else $error("Update finished with program enable still set.");
  a_no_read_live: assert property (
    start && req.op == dee_pkg::DOP_TBL_RD |-> !live_ff
  ) else $error("EEPROM read issued while a cycle is running.");
  a_apb_answer: assert property (
    setup |=> pready_ff ##1 !pready_ff
  ) else $error("APB access phase did not answer in one cycle.");

  c_blk_erase: cover property (fin && cmd_ff == dee_pkg::CMD_ERASE_BLOCK);
  c_word_write: cover property (fin && cmd_ff == dee_pkg::CMD_WRITE_WORD && phase_ff);
  c_read: cover property (st_ff == dee_pkg::ST_TREAD && pdone);
  c_late: cover property (tmr_exp);
endmodule : dee_host

// ### rtl/dee_pkg.sv
// Types shared by the data EEPROM host modules.
package dee_pkg;
  typedef enum logic [1:0] {DOP_REG_WR, DOP_REG_RD, DOP_TBL_RD, DOP_TBL_ST} dee_dop_t;
  typedef enum logic [1:0] {CMD_READ, CMD_ERASE_WORD, CMD_ERASE_BLOCK, CMD_WRITE_WORD} dee_cmd_t;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADRL, ST_ADRU, ST_CTRL, ST_KEY1, ST_KEY2, ST_GO, ST_POLL,
    ST_FLRD, ST_FLWR, ST_TSTORE, ST_TREAD, ST_DISEN
  } dee_st_t;
  typedef struct packed {
    dee_dop_t op;
    logic [6:0] page;
    logic [15:0] addr;
    logic [15:0] data;
  } dee_dreq_t;
endpackage : dee_pkg

// ### rtl/dee_tmr.sv
// Cycle timer that flags an erase or program cycle running past its documented time.
`timescale 1ns/1ps
`include "dee_cfg.svh"
module dee_tmr #(
  parameter int unsigned CYC = `DEE_CYCLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  output logic expired
);
  localparam logic [23:0] CYC_M1 = 24'(CYC - 1);
  logic [23:0] cnt_ff;
  logic expired_ff;

  if (CYC < 1 || CYC > 24'hffffff) begin : g_bad_cyc
    $error("Timer count out of range.");
  end

  // Counts while run is high and holds once expired; a drop of run restarts the count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 24'h000000;
      expired_ff <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_ff <= 24'h000000;
        expired_ff <= 1'b0;
      end else if (!expired_ff) begin
        cnt_ff <= cnt_ff + 24'h000001;
        expired_ff <= (cnt_ff == CYC_M1);
      end
    end
  end

  assign expired = expired_ff;

  a_tmr_span: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(expired_ff) |-> $past(cnt_ff) == CYC_M1 && $past(run)
  ) else $error("Cycle timer expired at the wrong count.");
endmodule : dee_tmr

// ### verification/dee_dev_model.sv
// Behavioural model of the device's nonvolatile controller and its data EEPROM array.
`timescale 1ns/1ps
`include "dee_cfg.svh"
module dee_dev_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic [15:0] cyc_len,
  input wire logic dev_valid,
  input wire dee_pkg::dee_dreq_t dev_req,
  output logic dev_ack,
  output logic [15:0] dev_rdata
);
  logic [15:0] mem_ff [512];
  logic [15:0] ctrl_ff, adrl_ff, flag_ff, latch_ff, cnt_ff, tick_ff;
  logic [6:0] adru_ff;
  logic [1:0] key_ff, wait_ff;
  logic take;
  // A slow device keeps the host waiting two extra cycles on each access.
  assign dev_ack = dev_valid && wait_ff == (slow ? 2'd2 : 2'd0);
  assign take = dev_valid && dev_ack;
  // Wait counter, plus a tick that scrambles read data outside an ack.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 2'd0;
      tick_ff <= 16'h0;
    end else begin
      wait_ff <= take || !dev_valid ? 2'd0 : wait_ff + 2'd1;
      tick_ff <= tick_ff + 16'h3c5;
    end
  end
  // Read data; array reads in a cycle give inverted words because their value is unspecified.
  always_comb begin
    dev_rdata = tick_ff;
    if (take && dev_req.op == dee_pkg::DOP_TBL_RD) begin
      dev_rdata = ctrl_ff[15] ? ~mem_ff[dev_req.addr[9:1]] : mem_ff[dev_req.addr[9:1]];
    end else if (take && dev_req.op == dee_pkg::DOP_REG_RD) begin
      case (dev_req.addr)
        `DEE_DEV_CTRL_ADDR: dev_rdata = ctrl_ff;
        `DEE_DEV_ADRL_ADDR: dev_rdata = adrl_ff;
        `DEE_DEV_ADRU_ADDR: dev_rdata = {9'h0, adru_ff};
        `DEE_DEV_FLAG_ADDR: dev_rdata = flag_ff;
        default: dev_rdata = 16'h0;
      endcase
    end
  end
  // Registers, unlock tracker and the background erase or program cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= 16'h0;
      adrl_ff <= 16'h0;
      adru_ff <= 7'h0;
      flag_ff <= 16'h0;
      latch_ff <= 16'h0;
      cnt_ff <= 16'h0;
      key_ff <= 2'd0;
      for (int i = 0; i < 512; i++) mem_ff[i] <= 16'h0;
    end else begin
      if (ctrl_ff[15]) begin
        cnt_ff <= cnt_ff + 16'h1;
        if (cnt_ff + 16'h1 >= cyc_len) begin
          case (ctrl_ff[6:0])
            7'h45: for (int i = 0; i < 16; i++) mem_ff[{adrl_ff[9:5], i[3:0]}] <= 16'hffff;
            7'h44: mem_ff[adrl_ff[9:1]] <= 16'hffff;
            7'h04: mem_ff[adrl_ff[9:1]] <= latch_ff;
            default: ;
          endcase
          ctrl_ff[15] <= 1'b0;
          flag_ff[12] <= 1'b1;
          cnt_ff <= 16'h0;
        end
      end
      if (take && dev_req.op == dee_pkg::DOP_TBL_ST) begin
        latch_ff <= dev_req.data;
        adrl_ff <= dev_req.addr;
        adru_ff <= dev_req.page;
      end
      if (take && dev_req.op == dee_pkg::DOP_REG_WR) begin
        key_ff <= 2'd0;
        case (dev_req.addr)
          `DEE_DEV_CTRL_ADDR: begin
            ctrl_ff[14] <= dev_req.data[14];
            if (!ctrl_ff[15]) ctrl_ff[6:0] <= dev_req.data[6:0];
            if (dev_req.data[15] && ctrl_ff[14] && key_ff == 2'd2) ctrl_ff[15] <= 1'b1;
          end
          `DEE_DEV_KEY_ADDR: key_ff <= dev_req.data == `DEE_KEY_FIRST ? 2'd1 :
            (dev_req.data == `DEE_KEY_SECOND && key_ff == 2'd1) ? 2'd2 : 2'd0;
          `DEE_DEV_ADRL_ADDR: adrl_ff <= dev_req.data;
          `DEE_DEV_ADRU_ADDR: adru_ff <= dev_req.data[6:0];
          `DEE_DEV_FLAG_ADDR: flag_ff <= dev_req.data;
          default: ;
        endcase
      end
    end
  end
endmodule : dee_dev_model

// ### verification/tb_top.sv
// Testbench for the data EEPROM host: APB tasks, device model and command sequences.
`timescale 1ns/1ps
`include "dee_cfg.svh"
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic [15:0] cyc_len = 16'h0008;
  logic [31:0] prdata, r;
  logic pready, pslverr, dev_valid, dev_ack, last_err;
  logic [15:0] dev_rdata;
  dee_pkg::dee_dreq_t dev_req;
  int miscompares = 0;
  int n_checks = 0;
  localparam logic [22:0] ADR_A = 23'h7ffc10;
  localparam logic [22:0] ADR_B = 23'h7ffc20;
  // Clock of 100 MHz.
  always #5 pclk = ~pclk;
  dee_host #(.CYCLE_CYC(20)) dee_host_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev_valid(dev_valid), .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
  dee_dev_model dee_dev_model_i (.pclk(pclk), .presetn(presetn), .slow(slow), .cyc_len(cyc_len),
    .dev_valid(dev_valid), .dev_req(dev_req), .dev_ack(dev_ack), .dev_rdata(dev_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count is assumed here; a missing answer is caught by the watchdog.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic apb_wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : apb_wr
  task automatic apb_rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : apb_rd
  task automatic launch(input dee_pkg::dee_cmd_t op, input logic [22:0] adr, input logic [15:0] wd);
    apb_wr(`DEE_ADR_OFS, {9'h0, adr});
    apb_wr(`DEE_WDAT_OFS, {16'h0, wd});
    apb_wr(`DEE_CMD_OFS, 32'h100 | 32'(op));
  endtask : launch
  // Polls busy under a bound, compares the final status, then clears the sticky bits.
  task automatic wait_done(input logic [31:0] st_exp);
    int n;
    n = 0;
    do begin
      apb_rd(`DEE_STAT_OFS);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    chk(r, st_exp);
    apb_wr(`DEE_STAT_OFS, 32'hf);
  endtask : wait_done
  task automatic read_word(input logic [22:0] adr, input logic [15:0] exp);
    launch(dee_pkg::CMD_READ, adr, 16'h0);
    wait_done(32'h2);
    apb_rd(`DEE_RDAT_OFS);
    chk(r, {16'h0, exp});
  endtask : read_word
  task automatic finish_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Main sequence: reset, a word update, a slow block erase with a refused write, a late word erase.
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb_rd(`DEE_STAT_OFS);
    chk(r, 32'h0);
    apb_rd(12'h020);
    chk({r[31:1], last_err}, 32'h1);
    launch(dee_pkg::CMD_WRITE_WORD, ADR_A, 16'h1234);
    wait_done(32'h2);
    chk({31'h0, dee_dev_model_i.ctrl_ff[14]}, 32'h0);
    read_word(ADR_A, 16'h1234);
    read_word(ADR_A + 23'h2, 16'h0);
    slow <= 1'b1;
    launch(dee_pkg::CMD_ERASE_BLOCK, ADR_A, 16'h0);
    apb_wr(`DEE_ADR_OFS, {9'h0, ADR_B});
    apb_rd(`DEE_STAT_OFS);
    chk({31'h0, r[0]}, 32'h1);
    wait_done(32'h2);
    apb_rd(`DEE_ADR_OFS);
    chk(r, {9'h0, ADR_A});
    slow <= 1'b0;
    read_word(ADR_A, 16'hffff);
    read_word(ADR_A + 23'h2, 16'hffff);
    read_word(ADR_B, 16'h0);
    cyc_len <= 16'h0028;
    launch(dee_pkg::CMD_ERASE_WORD, ADR_B, 16'h0);
    wait_done(32'ha);
    read_word(ADR_B, 16'hffff);
    read_word(ADR_B + 23'h2, 16'h0);
    chk({31'h0, dee_dev_model_i.flag_ff[12]}, 32'h0);
    finish_test;
  end
  // Watchdog sized well above the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    finish_test;
  end
endmodule : tb_top
